// [hdl/sync_check_pkg.sv]
/*
  Shared constants, field layouts, state encoding and carrier structs of the
  synchro check control block.
  Assumes a 32-bit classic Wishbone register bus and a 40 MHz system clock.
*/
package sync_check_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00; // mode and voltage choice
  localparam logic [7:0] AUTO_LIM_OFF = 8'h04; // auto voltage / frequency limits
  localparam logic [7:0] AUTO_TIM_OFF = 8'h08; // auto angle limit / timeout
  localparam logic [7:0] MAN_LIM_OFF = 8'h0c; // manual voltage / frequency limits
  localparam logic [7:0] MAN_TIM_OFF = 8'h10; // manual angle limit / timeout
  localparam logic [7:0] STAT_OFF = 8'h14; // read-only status

  // control register fields
  localparam int MODE_LSB = 0; // 2-bit operating mode
  localparam int VSEL_LSB = 2; // 3-bit voltage choice
  localparam logic [1:0] MODE_OFF = 2'h0; // function disabled
  localparam logic [1:0] MODE_ON = 2'h1; // normal checking
  localparam logic [1:0] MODE_BYPASS = 2'h2; // release regardless of measurements, pass requests
  localparam logic [1:0] MODE_RST = MODE_OFF;
  localparam logic [2:0] VSEL_RST = 3'h0; // first phase-to-neutral voltage
  localparam logic [2:0] VSEL_LAST = 3'h5; // six choices, 0..5
  localparam logic [31:0] LIM_RST = 32'h0000_0000;

  // timing
  localparam int unsigned CLK_HZ = 40_000_000; // 25 ns period
  localparam int unsigned BLOCK_MS = 1000; // hold-off after bus change
  localparam int unsigned MS_CYC = CLK_HZ / 1000; // cycles per millisecond
  localparam int unsigned BLOCK_CYC = BLOCK_MS * MS_CYC;

  // per-path procedure, gray along idle -> check -> close
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_CLOSE = 2'b11
  } proc_state_e;

  // measured values of one bus section
  typedef struct packed {
    logic [15:0] mag; // voltage magnitude
    logic [15:0] freq; // frequency
    logic [15:0] angle; // signed phase angle relative to line
  } bus_meas_s;

  // line measurements: six voltage magnitudes plus weighted-sum frequency
  typedef struct packed {
    logic [5:0][15:0] mag; // L1N,L2N,L3N,L12,L23,L31
    logic [15:0] freq_wsum; // frequency from all three phases
  } line_meas_s;

  // per-path limits held in registers
  typedef struct packed {
    logic [15:0] f_lim;
    logic [15:0] u_lim;
    logic [15:0] timeout_ms;
    logic [15:0] ang_lim;
  } path_cfg_s;

  // per-path output flags
  typedef struct packed {
    logic release_ok;
    logic in_prog;
    logic cmd;
    logic u_ok;
    logic f_ok;
    logic ang_ok;
  } path_out_s;

endpackage : sync_check_pkg

// [hdl/sync_check_ctrl.sv]
/*
  Synchro check control: common voltage selection, two evaluation paths
  (automatic, manual), blocking, bus-change hold-off and a Wishbone slave.
  Assumes synchronous inputs on clk and measurement values already
  produced upstream; the close commands go to output contacts only.
*/
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps

// Functional notes
// R1: block input disables whole function
// R2: line transformer supervision block disables function
// R3: only selected bus supervision block disables
// R4: disabled mode setting disables function
// R5: bus choice true selects second bus
// R6: setting picks one of six line voltages
// R7: auto request starts automatic checking procedure
// R8: manual request starts independent manual procedure
// R9: auto cancel stops procedure, no command
// R10: manual cancel stops procedure, no command
// R11: auto release output when closing permitted
// R12: manual release output when closing permitted
// R13: per-path in-progress while procedure runs
// R14: separate per-path close command outputs
// R15: combined command is OR of both
// R16: per-path voltage difference ok flag
// R17: per-path frequency difference ok flag
// R18: per-path angle difference ok flag
// R19: frequency from weighted three-phase sum
// R20: one common stage, two evaluation paths
// R21: commands drive contacts, not user logic
// R22: bus change blocks outputs one second
// R23: six voltage choices, default first phase-neutral
// R24: bypass releases and passes requests through
// R25: blocked function clears outputs, abandons procedures
module sync_check_ctrl #(
  parameter int unsigned BLOCK_CYCLES = sync_check_pkg::BLOCK_CYC, // hold-off length
  parameter int unsigned MS_CYCLES = sync_check_pkg::MS_CYC // timeout tick
) (
  input wire logic clk,
  input wire logic rst,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // measurements
  input wire sync_check_pkg::line_meas_s line_three_phase_phasors,
  input wire sync_check_pkg::bus_meas_s first_bus_phasor,
  input wire sync_check_pkg::bus_meas_s second_bus_phasor,
  // binary inputs
  input wire logic function_block_in,
  input wire logic bus_choice_in,
  input wire logic line_vt_block_in,
  input wire logic bus_one_vt_block_in,
  input wire logic bus_two_vt_block_in,
  input wire logic auto_close_request_in,
  input wire logic auto_cancel_in,
  input wire logic manual_close_request_in,
  input wire logic manual_cancel_in,
  // outputs
  output logic auto_release_out,
  output logic auto_in_progress_out,
  output logic auto_close_cmd_out,
  output logic auto_voltage_ok_out,
  output logic auto_freq_ok_out,
  output logic auto_angle_ok_out,
  output logic manual_release_out,
  output logic manual_in_progress_out,
  output logic manual_close_cmd_out,
  output logic manual_voltage_ok_out,
  output logic manual_freq_ok_out,
  output logic manual_angle_ok_out,
  output logic combined_close_cmd_out
);
  import sync_check_pkg::*;

  // absolute difference of two unsigned values
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction : abs_diff

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  logic [1:0] mode_r; // operating mode
  logic [2:0] vsel_r; // line voltage choice
  path_cfg_s cfg_r [2]; // limits, index 0 auto, 1 manual
  logic ack_r; // bus acknowledge
  logic [31:0] rdat_r; // read data
  logic bus_prev_r; // bus choice of the previous cycle
  logic [25:0] hold_cnt_r; // bus-change hold-off counter
  logic [15:0] tick_cnt_r; // millisecond prescaler
  logic ms_tick; // one-cycle pulse each millisecond
  path_out_s out_r [2]; // registered path outputs
  proc_state_e st_r [2]; // path procedure states
  logic [15:0] ms_cnt_r [2]; // per-path elapsed milliseconds
  logic [1:0] cmd_nxt; // next command per path
  logic comb_r; // combined command flop

  // common stage: selected voltages and differences
  logic [15:0] line_mag;
  bus_meas_s bus_sel;
  logic [15:0] u_diff;
  logic [15:0] f_diff;
  logic [15:0] ang_abs;
  logic bus_vt_blk;
  logic disabled;
  logic hold;
  logic [1:0] req;
  logic [1:0] cancel;

  assign line_mag = line_three_phase_phasors.mag[(vsel_r > VSEL_LAST) ? VSEL_RST : vsel_r]; // R6 R23
  assign bus_sel = bus_choice_in ? second_bus_phasor : first_bus_phasor; // R5 R20
  assign u_diff = abs_diff(line_mag, bus_sel.mag);
  assign f_diff = abs_diff(line_three_phase_phasors.freq_wsum, bus_sel.freq); // R19
  assign ang_abs = bus_sel.angle[15] ? 16'(-bus_sel.angle) : bus_sel.angle;
  assign bus_vt_blk = bus_choice_in ? bus_two_vt_block_in : bus_one_vt_block_in; // R3
  // any blocking condition turns the whole function off
  assign disabled = function_block_in || line_vt_block_in || bus_vt_blk || (mode_r == MODE_OFF); // R1 R2 R4
  // hold starts in the very cycle the bus choice moves
  assign hold = (hold_cnt_r != 26'h0) || (bus_choice_in != bus_prev_r); // R22
  assign req = {manual_close_request_in, auto_close_request_in}; // R7 R8
  assign cancel = {manual_cancel_in, auto_cancel_in};
  assign ms_tick = (tick_cnt_r == 16'(MS_CYCLES - 1));

  // wishbone slave: one wait state, ack drops the cycle after it rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
      if (cyc_i && stb_i && !ack_r) begin
        case (adr_i)
          CTRL_OFF: rdat_r <= {27'h0, vsel_r, mode_r};
          AUTO_LIM_OFF: rdat_r <= {cfg_r[0].f_lim, cfg_r[0].u_lim};
          AUTO_TIM_OFF: rdat_r <= {cfg_r[0].timeout_ms, cfg_r[0].ang_lim};
          MAN_LIM_OFF: rdat_r <= {cfg_r[1].f_lim, cfg_r[1].u_lim};
          MAN_TIM_OFF: rdat_r <= {cfg_r[1].timeout_ms, cfg_r[1].ang_lim};
          STAT_OFF: rdat_r <= {22'h0, st_r[1], st_r[0], bus_choice_in, hold, disabled, comb_r, 2'b00};
          default: rdat_r <= 32'h0000_0000; // unmapped reads zero, still acked
        endcase
      end
    end
  end

  // configuration writes take effect at the ack edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_RST;
      vsel_r <= VSEL_RST; // R23
      cfg_r[0] <= LIM_RST + 64'h0;
      cfg_r[1] <= LIM_RST + 64'h0;
    end else if (cyc_i && stb_i && we_i && ack_r) begin
      case (adr_i)
        CTRL_OFF: begin
          if (sel_i[0]) begin
            mode_r <= dat_i[MODE_LSB +: 2];
            vsel_r <= dat_i[VSEL_LSB +: 3];
          end
        end
        AUTO_LIM_OFF: cfg_r[0][63:32] <= merge(cfg_r[0][63:32], dat_i, sel_i);
        AUTO_TIM_OFF: cfg_r[0][31:0] <= merge(cfg_r[0][31:0], dat_i, sel_i);
        MAN_LIM_OFF: cfg_r[1][63:32] <= merge(cfg_r[1][63:32], dat_i, sel_i);
        MAN_TIM_OFF: cfg_r[1][31:0] <= merge(cfg_r[1][31:0], dat_i, sel_i);
        default: ; // read-only or unmapped: ignored
      endcase
    end
  end

  // bus-change hold-off; restarts on every further change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_prev_r <= 1'b0;
      hold_cnt_r <= 26'h0;
    end else begin
      bus_prev_r <= bus_choice_in;
      if (bus_choice_in != bus_prev_r) begin
        hold_cnt_r <= 26'(BLOCK_CYCLES - 1); // R22
      end else if (hold_cnt_r != 26'h0) begin
        hold_cnt_r <= hold_cnt_r - 26'h1;
      end
    end
  end

  // millisecond prescaler for procedure timeouts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 16'h0;
    end else begin
      tick_cnt_r <= ms_tick ? 16'h0 : tick_cnt_r + 16'h1;
    end
  end

  // two identical evaluation paths sharing the common stage
  for (genvar p = 0; p < 2; p++) begin : g_path // R20
    logic u_ok;
    logic f_ok;
    logic a_ok;
    logic rel;
    proc_state_e st_nxt;

    assign u_ok = (u_diff <= cfg_r[p].u_lim); // R16
    assign f_ok = (f_diff <= cfg_r[p].f_lim); // R17
    assign a_ok = (ang_abs <= cfg_r[p].ang_lim); // R18
    // bypass releases without looking at the measurements
    assign rel = !disabled && !hold && ((mode_r == MODE_BYPASS) || (u_ok && f_ok && a_ok)); // R11 R12 R24

    // procedure next state
    always_comb begin
      st_nxt = st_r[p];
      cmd_nxt[p] = 1'b0;
      if (disabled || mode_r == MODE_BYPASS || cancel[p]) begin
        st_nxt = ST_IDLE; // R9 R10 R25
        cmd_nxt[p] = (mode_r == MODE_BYPASS) && !disabled && !hold && !cancel[p] && req[p]; // R24
      end else begin
        case (st_r[p])
          ST_IDLE: begin
            if (req[p]) begin
              st_nxt = ST_CHECK; // R7 R8
            end
          end
          ST_CHECK: begin
            if (!req[p]) begin
              st_nxt = ST_IDLE; // request withdrawn
            end else if (rel) begin
              st_nxt = ST_CLOSE;
              cmd_nxt[p] = 1'b1; // R14
            end else if (ms_tick && ms_cnt_r[p] >= cfg_r[p].timeout_ms) begin
              st_nxt = ST_IDLE; // closing declined on timeout
            end
          end
          ST_CLOSE: begin
            // command stands while the request does, cut by a bus hold-off
            cmd_nxt[p] = req[p] && !hold;
            if (!req[p]) begin
              st_nxt = ST_IDLE;
            end
          end
          default: st_nxt = ST_IDLE;
        endcase
      end
    end

    // state, elapsed time and output flags
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        st_r[p] <= ST_IDLE;
        ms_cnt_r[p] <= 16'h0;
        out_r[p] <= '0;
      end else begin
        st_r[p] <= st_nxt;
        if (st_nxt != ST_CHECK) begin
          ms_cnt_r[p] <= 16'h0;
        end else if (ms_tick && ms_cnt_r[p] != 16'hffff) begin
          ms_cnt_r[p] <= ms_cnt_r[p] + 16'h1;
        end
        out_r[p].release_ok <= rel;
        out_r[p].in_prog <= (st_nxt != ST_IDLE); // R13
        out_r[p].cmd <= cmd_nxt[p];
        out_r[p].u_ok <= u_ok && !disabled;
        out_r[p].f_ok <= f_ok && !disabled;
        out_r[p].ang_ok <= a_ok && !disabled;
      end
    end
  end

  // combined command, kept in step with the path commands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comb_r <= 1'b0;
    end else begin
      comb_r <= |cmd_nxt; // R15 R21
    end
  end

  assign dat_o = rdat_r;
  assign ack_o = ack_r;
  assign auto_release_out = out_r[0].release_ok;
  assign auto_in_progress_out = out_r[0].in_prog;
  assign auto_close_cmd_out = out_r[0].cmd;
  assign auto_voltage_ok_out = out_r[0].u_ok;
  assign auto_freq_ok_out = out_r[0].f_ok;
  assign auto_angle_ok_out = out_r[0].ang_ok;
  assign manual_release_out = out_r[1].release_ok;
  assign manual_in_progress_out = out_r[1].in_prog;
  assign manual_close_cmd_out = out_r[1].cmd;
  assign manual_voltage_ok_out = out_r[1].u_ok;
  assign manual_freq_ok_out = out_r[1].f_ok;
  assign manual_angle_ok_out = out_r[1].ang_ok;
  assign combined_close_cmd_out = comb_r;

  // checks
  block_off_a: assert property (@(posedge clk) disable iff (rst) // R1
    function_block_in |=> !auto_release_out && !manual_release_out && !combined_close_cmd_out)
    else $error("block input did not clear outputs");

  line_vt_a: assert property (@(posedge clk) disable iff (rst) // R2
    line_vt_block_in |=> !auto_in_progress_out && !manual_in_progress_out && !auto_release_out)
    else $error("line supervision block ignored");

  bus_vt_a: assert property (@(posedge clk) disable iff (rst) // R3
    (bus_choice_in ? bus_two_vt_block_in : bus_one_vt_block_in) |=> !combined_close_cmd_out && !manual_release_out)
    else $error("selected bus supervision block ignored");

  mode_off_a: assert property (@(posedge clk) disable iff (rst) // R4
    (mode_r == MODE_OFF) |=> !auto_release_out && !manual_in_progress_out)
    else $error("disabled mode still active");

  auto_cancel_a: assert property (@(posedge clk) disable iff (rst) // R9
    auto_cancel_in |=> !auto_close_cmd_out && !auto_in_progress_out)
    else $error("auto cancel did not stop procedure");

  man_cancel_a: assert property (@(posedge clk) disable iff (rst) // R10
    manual_cancel_in |=> !manual_close_cmd_out && !manual_in_progress_out)
    else $error("manual cancel did not stop procedure");

  auto_start_a: assert property (@(posedge clk) disable iff (rst) // R13
    $rose(auto_in_progress_out) |-> $past(auto_close_request_in))
    else $error("auto procedure started without request");

  comb_or_a: assert property (@(posedge clk) disable iff (rst) // R15
    combined_close_cmd_out == (auto_close_cmd_out || manual_close_cmd_out))
    else $error("combined command is not the OR of paths");

  bus_hold_a: assert property (@(posedge clk) disable iff (rst) // R22
    $changed(bus_choice_in) |=> (!auto_release_out && !combined_close_cmd_out) [*8])
    else $error("outputs not held off after bus change");

  bypass_rel_a: assert property (@(posedge clk) disable iff (rst) // R24
    (mode_r == MODE_BYPASS && !disabled && !hold) |=> auto_release_out && manual_release_out)
    else $error("bypass did not release");

endmodule : sync_check_ctrl

// [dv/close_partner.sv]
/*
  close-request partner: the reclosing and manual close logic that hold a
  request level per path, and the breaker contacts fed by the commands.
  assumes go/stop pulses from the bench, changed just after rising clk.
*/
`timescale 1ns/1ps
module close_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] go, // start a request, bit 0 automatic
  input wire logic [1:0] stop, // withdraw a request
  input wire logic [1:0] cmd, // per-path close commands
  output logic [1:0] req,
  output logic closed
);
  logic [1:0] req_r; // request levels
  logic closed_r; // breaker position
  // a request is a level held until withdrawn, never a pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_r <= 2'h0;
    end else begin
      req_r <= (req_r | go) & ~stop;
    end
  end
  // contacts latch closed on any command; only reset reopens them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      closed_r <= 1'h0;
    end else if (|cmd) begin
      closed_r <= 1'h1;
    end
  end
  assign req = req_r;
  assign closed = closed_r;
endmodule : close_partner

// [dv/synchro_check_control_tb.sv]
/*
  bench of the synchro check control block: wishbone tasks, the close
  partner and directed scenarios with worked-out expected values.
  assumes the design package; the hold-off is shortened by parameter.
*/
`timescale 1ns/1ps
module synchro_check_control_tb;
  import sync_check_pkg::*;
  localparam int unsigned HOLD = 20; // short hold-off keeps the run brief
  logic clk, rst, cyc_i, stb_i, we_i, ack_o, bus_choice_in;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [3:0] blk; // function, line vt, bus one vt, bus two vt
  logic [31:0] dat_i, dat_o;
  logic [1:0] go, stop, cnc;
  wire [1:0] req, rel, ip, cmd, uok, fok, aok; // index 0 automatic, 1 manual
  wire comb, closed;
  line_meas_s line;
  bus_meas_s bus1, bus2;
  int fail_count, n_tests;

  sync_check_ctrl #(.BLOCK_CYCLES(HOLD), .MS_CYCLES(4)) u_dut (
    .clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .line_three_phase_phasors(line), .first_bus_phasor(bus1), .second_bus_phasor(bus2),
    .function_block_in(blk[0]), .bus_choice_in, .line_vt_block_in(blk[1]),
    .bus_one_vt_block_in(blk[2]), .bus_two_vt_block_in(blk[3]),
    .auto_close_request_in(req[0]), .auto_cancel_in(cnc[0]),
    .manual_close_request_in(req[1]), .manual_cancel_in(cnc[1]),
    .auto_release_out(rel[0]), .auto_in_progress_out(ip[0]), .auto_close_cmd_out(cmd[0]),
    .auto_voltage_ok_out(uok[0]), .auto_freq_ok_out(fok[0]), .auto_angle_ok_out(aok[0]),
    .manual_release_out(rel[1]), .manual_in_progress_out(ip[1]), .manual_close_cmd_out(cmd[1]),
    .manual_voltage_ok_out(uok[1]), .manual_freq_ok_out(fok[1]), .manual_angle_ok_out(aok[1]),
    .combined_close_cmd_out(comb));

  close_partner u_partner (.clk, .rst, .go, .stop, .cmd, .req, .closed);

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // cut a hang short; the whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    $display("watchdog expired");
    fail_count++;
    summarize();
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk_bit(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  // one classic cycle; the request stands until the edge at which ack is sampled high,
  // read data is taken at that same edge and only then is the request dropped
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // the wait itself has no cycle bound and only the watchdog ends a hung one; the count is then checked to be two
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'h1);
    chk_word("ack wait", 32'h2, 32'(n));
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i <= 1'h0;
  endtask : wb

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask : wr

  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    chk_word(nm, e, q);
  endtask : rdc

  // let n edges land, then look at settled outputs
  task automatic step(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : step

  task automatic close_path(int p);
    int n;
    n = 0;
    @(posedge clk) go[p] <= 1'h1;
    @(posedge clk) go[p] <= 1'h0;
    do begin
      @(negedge clk);
      n++;
    end while (ip[p] !== 1'h1 && n < 8);
    chk_bit("in progress", 1'h1, ip[p]);
    chk_bit("early command", 1'h0, cmd[p]);
    @(negedge clk);
    chk_bit("command", 1'h1, cmd[p]);
    chk_bit("combined", 1'h1, comb);
    chk_bit("release", 1'h1, rel[p]);
    chk_bit("other path", 1'h0, cmd[1-p]);
  endtask : close_path

  initial begin
    rst = 1'h1;
    {cyc_i, stb_i, we_i, bus_choice_in} = 4'h0;
    {adr_i, dat_i, blk, go, stop, cnc} = 50'h0;
    sel_i = 4'hf;
    line.freq_wsum = 16'h1388;
    for (int i = 0; i < 6; i++) line.mag[i] = 16'h2000 + 16'(i) * 16'h0100;
    bus1 = '{16'h2000, 16'h1388, 16'h0000};
    bus2 = bus1;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rdc("control", CTRL_OFF, {27'h0, VSEL_RST, MODE_RST});
    rdc("auto limits", AUTO_LIM_OFF, LIM_RST);
    wr(8'h1c, 32'hffff_ffff);
    rdc("unmapped", 8'h1c, 32'h0);
    // disabled mode: requests start nothing
    @(posedge clk) go <= 2'h3;
    @(posedge clk) go <= 2'h0;
    step(4);
    chk_bit("auto off", 1'h0, ip[0] | rel[0]);
    chk_bit("manual off", 1'h0, ip[1] | rel[1]);
    @(posedge clk) stop <= 2'h3;
    @(posedge clk) stop <= 2'h0;
    $display("test reset and off done");
    // manual limits wider than automatic, to tell the paths apart
    wr(AUTO_LIM_OFF, 32'h0010_0010);
    wr(AUTO_TIM_OFF, 32'hffff_0010);
    wr(MAN_LIM_OFF, 32'h0200_0200);
    wr(MAN_TIM_OFF, 32'hffff_0040);
    rdc("manual limits", MAN_LIM_OFF, 32'h0200_0200);
    wr(CTRL_OFF, {27'h0, VSEL_RST, MODE_ON});
    for (int p = 0; p < 2; p++) begin
      close_path(p);
      // bus one selected: its block counts, bus two block is ignored
      for (int k = 0; k < 4; k++) begin
        @(posedge clk) blk[k] <= 1'h1;
        step(2);
        chk_bit("blocked release", k == 3, rel[p]);
        chk_bit("blocked command", k == 3, cmd[p]);
        chk_bit("blocked progress", k == 3, ip[p]);
        @(posedge clk) blk[k] <= 1'h0;
        step(4);
        chk_bit("restart", 1'h1, cmd[p]);
      end
      @(posedge clk) cnc[p] <= 1'h1;
      step(3);
      chk_bit("cancelled", 1'h0, cmd[p] | ip[p]);
      @(posedge clk) stop[p] <= 1'h1;
      @(posedge clk) stop[p] <= 1'h0;
      cnc[p] <= 1'h0;
      step(2);
      chk_bit("idle", 1'h0, cmd[p] | comb);
    end
    chk_bit("breaker", 1'h1, closed);
    $display("test close block cancel done");
    for (int v = 0; v < 6; v++) begin
      wr(CTRL_OFF, {27'h0, 3'(v), MODE_ON});
      @(posedge clk) bus1.mag <= 16'h2000 + 16'(v) * 16'h0100;
      step(2);
      chk_bit("voltage ok", 1'h1, uok[0]);
      @(posedge clk) bus1.mag <= 16'h2080 + 16'(v) * 16'h0100;
      step(2);
      chk_bit("voltage off", 1'h0, uok[0]);
      chk_bit("manual voltage", 1'h1, uok[1]);
    end
    wr(CTRL_OFF, {27'h0, VSEL_RST, MODE_ON});
    @(posedge clk) line.freq_wsum <= 16'h1488;
    bus1 <= '{16'h2000, 16'h1388, 16'hfff8};
    step(2);
    chk_bit("auto freq", 1'h0, fok[0]);
    chk_bit("manual freq", 1'h1, fok[1]);
    chk_bit("negative angle", 1'h1, aok[0]);
    @(posedge clk) bus1.angle <= 16'h0020;
    step(2);
    chk_bit("auto angle", 1'h0, aok[0]);
    chk_bit("manual angle", 1'h1, aok[1]);
    chk_bit("auto release", 1'h0, rel[0]);
    $display("test voltage choice and limits done");
    // bus change while closed: second bus used, outputs held off
    @(posedge clk) line.freq_wsum <= 16'h1388;
    bus1.angle <= 16'h0000;
    close_path(0);
    @(posedge clk) bus_choice_in <= 1'h1;
    bus1.mag <= 16'h3000;
    step(2);
    chk_bit("second bus", 1'h1, uok[0]);
    chk_bit("hold release", 1'h0, rel[0]);
    chk_bit("hold command", 1'h0, comb);
    step(HOLD - 5);
    chk_bit("still held", 1'h0, rel[0]);
    step(10);
    chk_bit("hold over", 1'h1, rel[0]);
    @(posedge clk) stop[0] <= 1'h1;
    @(posedge clk) stop[0] <= 1'h0;
    $display("test bus change done");
    wr(CTRL_OFF, {27'h0, VSEL_RST, MODE_BYPASS});
    @(posedge clk) bus2.angle <= 16'h0100;
    @(posedge clk) go[0] <= 1'h1;
    @(posedge clk) go[0] <= 1'h0;
    step(2);
    chk_bit("bypass release", 1'h1, rel[0]);
    chk_bit("bypass command", 1'h1, cmd[0]);
    chk_bit("bypass progress", 1'h0, ip[0]);
    // status: combined command up, second bus selected, paths idle
    rdc("status", STAT_OFF, 32'h0000_0024);
    $display("test bypass done");
    summarize();
  end
endmodule : synchro_check_control_tb
